// ### ppm_host.sv
/*
 Host processor model: an APB master with one transfer task.
 Assumes the caller enters the task just after a rising edge.
*/
`timescale 1ns/10ps
`default_nettype none
module ppm_host
(
   input  wire logic        clk,
   output var  logic        psel,
   output var  logic        penable,
   output var  logic        pwrite,
   output var  logic [11:0] paddr,
   output var  logic [31:0] pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
   end
   // Every access also wakes the device from standby or deep sleep
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err, output logic to);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      to = (n >= 50);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : xfer
endmodule : ppm_host
`default_nettype wire

// ### ppm_monitor.sv
/*
 Port checker for ppm_top, bound at the foot of this file.
 Assumes one clock and the synchronous active-high reset.
*/
`timescale 1ns/10ps
`default_nettype none
module ppm_monitor
(
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic       psel,
   input  wire logic       penable,
   input  wire logic       pready,
   input  wire logic       pslverr,
   input  wire logic       busy_n,
   input  wire logic [4:0] power_state,
   input  wire logic       clk_full,
   input  wire logic       clk_reduced,
   input  wire logic       regulators_on
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   rst_state_a: assert property (disable iff (1'b0) sys_rst |=> power_state == 5'h01 && !busy_n)
      else $error("reset state not entered");
   busy_hold_a: assert property ($fell(sys_rst) |-> !busy_n [*8])
      else $error("busy released early");
   busy_refuse_a: assert property (psel && penable && pready && !busy_n |-> pslverr)
      else $error("access taken while busy");
   ready_time_a: assert property (psel && $rose(penable) |=> pready)
      else $error("ready late");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   state_onehot_a: assert property ($onehot(power_state))
      else $error("power state not one-hot");
   deep_power_a: assert property (power_state == 5'h10 [*2] |-> !regulators_on)
      else $error("regulators on in deep sleep");
   turbo_clock_a: assert property (power_state == 5'h02 [*2] |-> clk_full && !clk_reduced)
      else $error("turbo clocks wrong");
   psave_clock_a: assert property (power_state == 5'h04 [*2] |-> clk_reduced && !clk_full)
      else $error("power-save clocks wrong");
   deep_wake_a: assert property (power_state == 5'h10 && psel && !penable |-> ##[1:3] power_state != 5'h10)
      else $error("no wake from deep sleep");
   deep_c: cover property (power_state == 5'h10);
   standby_c: cover property (power_state == 5'h08);
   denied_c: cover property (pready && pslverr && busy_n);
endmodule : ppm_monitor
bind ppm_top ppm_monitor ppm_monitor_inst (.clk, .sys_rst, .psel, .penable, .pready, .pslverr, .busy_n,
   .power_state, .clk_full, .clk_reduced, .regulators_on);
`default_nettype wire

// ### ppm_pkg.sv
/*
 Constants, register map and types for the partition protection and power
 mode controller. Assumes an APB master with 32-bit data and a 100 MHz clock.
*/
`default_nettype none
// How it works
// (R1) Each partition has own read/write protect bits
// (R2) Each partition has a 64-bit key
// (R3) Matching key lifts protection; removal restores it
// (R4) No access or attribute change without key
// (R5) Key dropped on deep sleep or removal
// (R6) Lock option plus lock pin denies access
// (R7) Session lock bit acts like lock pin
// (R8) Session lock sets only; reset clears it
// (R9) 16-byte serial is read-only
// (R10) Write-once partition takes one write only
// (R11) Erase refused on write-once partitions always
// (R12) Five power states in two groups
// (R13) Reset pin forces reset state
// (R14) Leave reset into configured work mode
// (R15) Host access wakes; idle only if enabled
// (R16) Reset state drops writes, reads junk
// (R17) Turbo full clock, power-save reduced clock
// (R18) Standby on inactivity, no wake latency
// (R19) Deep-sleep bit forces deep sleep
// (R20) Auto deep sleep, direct or via standby
// (R21) Deep sleep keeps all registers; the code clears key_in and the deep-sleep bit there
// (R22) Host access or reset exits deep sleep
// (R23) Busy held after reset during boot load
// (R24) Inactivity timer restarts on each access
package ppm_pkg;
   localparam int NPART = 4;
   // ----------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [11:0] OFS_PART_SEL  = 12'h000;
   localparam logic [11:0] OFS_ATTR      = 12'h004;
   localparam logic [11:0] OFS_KEY_LO    = 12'h008;
   localparam logic [11:0] OFS_KEY_HI    = 12'h00C;
   localparam logic [11:0] OFS_KEY_CMD   = 12'h010;
   localparam logic [11:0] OFS_SW_LOCK   = 12'h014;
   localparam logic [11:0] OFS_POWER     = 12'h018;
   localparam logic [11:0] OFS_IDLE_TIME = 12'h01C;
   localparam logic [11:0] OFS_DEEP_TIME = 12'h020;
   localparam logic [11:0] OFS_ACCESS    = 12'h024;
   localparam logic [11:0] OFS_STATUS    = 12'h028;
   localparam logic [11:0] OFS_SERIAL0   = 12'h030;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int ATTR_RD_PROT = 0;
   localparam int ATTR_WR_PROT = 1;
   localparam int ATTR_LOCK_EN = 2;
   localparam int ATTR_ONCE    = 3;
   localparam int ATTR_WRITTEN = 4;
   localparam int KCMD_INSERT  = 0;
   localparam int KCMD_REMOVE  = 1;
   localparam int PWR_PSAVE    = 0;
   localparam int PWR_AUTO_IDL = 1;
   localparam int PWR_DEEP_REQ = 2;
   localparam int PWR_AUTO_DPD = 3;
   localparam int PWR_DPD_VIA  = 4;
   localparam int ACC_WRITE    = 0;
   localparam int ACC_ERASE    = 1;
   // ----------------------------------------
   // Reset values and timing
   // ----------------------------------------
   localparam logic [31:0] IDLE_TIME_RST = 32'h0000_0400;
   localparam logic [31:0] DEEP_TIME_RST = 32'h0000_1000;
   localparam int          BOOT_NS       = 1000;
   localparam int          CLK_NS        = 10;
   localparam int          BOOT_CYC      = (BOOT_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [31:0] SERIAL_W0     = 32'h1234_5678; // Arbitrary value
   localparam logic [31:0] SERIAL_W1     = 32'h9ABC_DEF0; // Arbitrary value
   localparam logic [31:0] SERIAL_W2     = 32'h0F1E_2D3C; // Arbitrary value
   localparam logic [31:0] SERIAL_W3     = 32'h4B5A_6978; // Arbitrary value
   typedef enum logic [4:0] {
      PPM_RESET   = 5'b0_0001,
      PPM_TURBO   = 5'b0_0010,
      PPM_PSAVE   = 5'b0_0100,
      PPM_STANDBY = 5'b0_1000,
      PPM_DEEP    = 5'b1_0000
   } ppm_state_t;
endpackage : ppm_pkg
`default_nettype wire

// ### ppm_top.sv
/*
 Partition protection and power mode controller with APB register access.
 Assumes a synchronous lock pin; host activity other than APB arrives on
 host_access as a one-cycle pulse.
*/
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`default_nettype none
module ppm_top
   import ppm_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   input  wire logic        lock_n,
   input  wire logic        host_access,
   output var  logic        busy_n,
   output var  logic [4:0]  power_state,
   output var  logic        clk_full,
   output var  logic        clk_reduced,
   output var  logic        regulators_on
);
   // ----------------------------------------
   // Per-partition and shared storage
   // ----------------------------------------
   logic [4:0]        attr  [NPART];
   logic [63:0]       key   [NPART];
   logic [NPART-1:0]  key_in;
   logic [1:0]        sel;
   logic [63:0]       cand;
   logic              session_lock_bit;
   logic [4:0]        pwr_cfg;
   logic [31:0]       idle_time;
   logic [31:0]       deep_time;
   logic [31:0]       idle_cnt;
   logic [15:0]       boot_cnt;
   ppm_state_t        state;
   ppm_state_t        next_state;
   logic              last_denied;

   wire logic setup   = psel && !penable;
   wire logic wr      = psel && penable && pwrite && pready;
   wire logic in_rst  = (state == PPM_RESET);
   wire logic activity = host_access || setup;
   wire logic lock_now = !lock_n || session_lock_bit;

   // Effective access: key open and not hardware/session locked
   wire logic hw_lock = attr[sel][ATTR_LOCK_EN] && lock_now;        // (R6) (R7)
   wire logic open_ok = key_in[sel] && !hw_lock;                     // (R3)
   wire logic rd_ok   = !attr[sel][ATTR_RD_PROT] || open_ok;         // (R1)
   wire logic wr_ok   = (!attr[sel][ATTR_WR_PROT] || open_ok)
                        && !(attr[sel][ATTR_ONCE] && attr[sel][ATTR_WRITTEN]); // (R10)
   wire logic attr_ok = key_in[sel] || (attr[sel][ATTR_RD_PROT] == 1'b0
                        && attr[sel][ATTR_WR_PROT] == 1'b0);         // (R4)

   // ----------------------------------------
   // APB handshake
   // ----------------------------------------
   // One wait state gives a fixed two-cycle access and registered read data
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         pready <= 1'b0;
      else
         pready <= psel && penable && !pready;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else if (psel && penable && !pready)
      begin
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
         if (!busy_n)
            pslverr <= 1'b1;                                        // (R23)
         else if (pwrite)
            pslverr <= (paddr == OFS_ACCESS) &&
                       ((pwdata[ACC_ERASE] && attr[sel][ATTR_ONCE]) ||
                        (pwdata[ACC_WRITE] && !wr_ok) ||
                        (!pwdata[ACC_WRITE] && !rd_ok));            // (R4) (R11)
         else if (paddr == OFS_PART_SEL)
            prdata <= {30'h0, sel};
         else if (paddr == OFS_ATTR)
            prdata <= {27'h0, attr[sel]};
         else if (paddr == OFS_KEY_CMD)
            prdata <= {{(32-NPART){1'b0}}, key_in};
         else if (paddr == OFS_SW_LOCK)
            prdata <= {31'h0, session_lock_bit};
         else if (paddr == OFS_POWER)
            prdata <= {27'h0, pwr_cfg};
         else if (paddr == OFS_IDLE_TIME)
            prdata <= idle_time;
         else if (paddr == OFS_DEEP_TIME)
            prdata <= deep_time;
         else if (paddr == OFS_STATUS)
            prdata <= {24'h0, 2'b00, last_denied, state};
         else if (paddr == OFS_SERIAL0)
            prdata <= SERIAL_W0;                                    // (R9)
         else if (paddr == OFS_SERIAL0 + 12'h004)
            prdata <= SERIAL_W1;
         else if (paddr == OFS_SERIAL0 + 12'h008)
            prdata <= SERIAL_W2;
         else if (paddr == OFS_SERIAL0 + 12'h00C)
            prdata <= SERIAL_W3;
         else if (paddr != OFS_KEY_LO && paddr != OFS_KEY_HI && paddr != OFS_ACCESS)
            pslverr <= 1'b1;
      end
   end

   wire logic wr_live = wr && busy_n && !in_rst && !pslverr;        // (R16) (R23)

   // ----------------------------------------
   // Protection registers
   // ----------------------------------------
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         sel <= 2'b00;
      else if (wr_live && paddr == OFS_PART_SEL)
         sel <= pwdata[1:0];
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         cand <= 64'h0;
      else if (wr_live && paddr == OFS_KEY_LO)
         cand[31:0] <= pwdata;
      else if (wr_live && paddr == OFS_KEY_HI)
         cand[63:32] <= pwdata;
   end

   // The reset pin stands in for power-up: partitions start open, so software
   // can set them up without a key; unknown attributes would block every write
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         for (int i = 0; i < NPART; i++)
         begin
            attr[i] <= 5'h00;
            key[i]  <= 64'h0000_0000_0000_0000;
         end
      end
      else if (wr_live && paddr == OFS_ATTR && attr_ok)             // (R4)
      begin
         attr[sel][3:0] <= pwdata[3:0];
         key[sel]       <= cand;                                    // (R2)
      end
      else if (wr_live && paddr == OFS_ACCESS && pwdata[ACC_WRITE])
         attr[sel][ATTR_WRITTEN] <= attr[sel][ATTR_WRITTEN] | attr[sel][ATTR_ONCE]; // (R10)
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst || state == PPM_DEEP)
         key_in <= '0;                                              // (R5)
      else if (wr_live && paddr == OFS_KEY_CMD)
      begin
         if (pwdata[KCMD_REMOVE])
            key_in[sel] <= 1'b0;                                    // (R5)
         else if (pwdata[KCMD_INSERT])
            key_in[sel] <= (cand == key[sel]);                      // (R3)
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         session_lock_bit <= 1'b0;                                  // (R8)
      else if (wr_live && paddr == OFS_SW_LOCK && pwdata[0])
         session_lock_bit <= 1'b1;                                  // (R8)
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         last_denied <= 1'b0;
      else if (wr && busy_n && paddr == OFS_ACCESS)
         last_denied <= pslverr;
   end

   // ----------------------------------------
   // Power configuration
   // ----------------------------------------
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         pwr_cfg   <= 5'b0_0000;
         idle_time <= IDLE_TIME_RST;
         deep_time <= DEEP_TIME_RST;
      end
      else
      begin
         if (state == PPM_DEEP)
            pwr_cfg[PWR_DEEP_REQ] <= 1'b0;
         if (wr_live && paddr == OFS_POWER)
            pwr_cfg <= pwdata[4:0];                                 // (R14) (R19)
         if (wr_live && paddr == OFS_IDLE_TIME)
            idle_time <= pwdata;
         if (wr_live && paddr == OFS_DEEP_TIME)
            deep_time <= pwdata;
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst || activity)
         idle_cnt <= 32'h0;                                         // (R24)
      else if (idle_cnt != 32'hFFFF_FFFF)
         idle_cnt <= idle_cnt + 32'h1;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         boot_cnt <= 16'h0;
      else if (boot_cnt != 16'(BOOT_CYC))
         boot_cnt <= boot_cnt + 16'h1;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         busy_n <= 1'b0;                                            // (R23)
      else
         busy_n <= (boot_cnt == 16'(BOOT_CYC));
   end

   // ----------------------------------------
   // Power state machine
   // ----------------------------------------
   wire ppm_state_t work_st = pwr_cfg[PWR_PSAVE] ? PPM_PSAVE : PPM_TURBO; // (R14)

   always_comb
   begin
      next_state = state;
      case (state)
         PPM_RESET:
            if (busy_n)
               next_state = work_st;                                // (R14)
         PPM_TURBO, PPM_PSAVE:
            if (pwr_cfg[PWR_DEEP_REQ])
               next_state = PPM_DEEP;                               // (R19)
            else if (!activity && pwr_cfg[PWR_AUTO_DPD] && !pwr_cfg[PWR_DPD_VIA]
                     && idle_cnt >= idle_time)
               next_state = PPM_DEEP;                               // (R20)
            else if (!activity && (pwr_cfg[PWR_AUTO_IDL] || pwr_cfg[PWR_AUTO_DPD])
                     && idle_cnt >= idle_time)
               next_state = PPM_STANDBY;                            // (R18)
            else
               next_state = work_st;
         PPM_STANDBY:
            if (activity)
               next_state = work_st;                                // (R15) (R18)
            else if (pwr_cfg[PWR_AUTO_DPD] && idle_cnt >= idle_time + deep_time)
               next_state = PPM_DEEP;                               // (R20)
         PPM_DEEP:
            if (activity)
               next_state = work_st;                                // (R22) (R21)
         default:
            next_state = PPM_RESET;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         state <= PPM_RESET;                                        // (R13) (R12)
      else
         state <= next_state;
   end

   // Clock and regulator controls follow the next state so they match it
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         power_state   <= PPM_RESET;
         clk_full      <= 1'b1;
         clk_reduced   <= 1'b0;
         regulators_on <= 1'b1;
      end
      else
      begin
         power_state   <= next_state;
         clk_full      <= (next_state == PPM_TURBO) || (next_state == PPM_RESET); // (R17)
         clk_reduced   <= (next_state == PPM_PSAVE);                // (R17)
         regulators_on <= (next_state != PPM_DEEP);                 // (R19)
      end
   end

endmodule : ppm_top
`default_nettype wire

// ### test_partition_protect_power_modes.sv
/*
 Self-checking bench for ppm_top with the host model on APB.
 Assumes a 100 MHz clock; random partition and key from a fixed seed.
*/
`timescale 1ns/10ps
`default_nettype none
module test_partition_protect_power_modes
   import ppm_pkg::*;
;
   logic clk = 0, sys_rst = 1, lock_n = 1, host_access = 0;
   logic psel, penable, pwrite, pready, pslverr, busy_n, ev, to, kin, lk;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rv;
   logic [4:0] power_state;
   logic [63:0] key;
   logic [1:0] p;
   logic [31:0] sw [4] = '{SERIAL_W0, SERIAL_W1, SERIAL_W2, SERIAL_W3};
   integer seed = 32'hc054;
   int bad_count = 0, checked = 0;
   always #5 clk = ~clk;
   ppm_top ppm_top_inst (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .lock_n, .host_access, .busy_n, .power_state, .clk_full(), .clk_reduced(), .regulators_on());
   ppm_host ppm_host_inst (.clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : complete_run
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         bad_count++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      ppm_host_inst.xfer(w, a, d, rv, ev, to);
      if (to)
      begin
         chk("pready", 1, 0);
         complete_run();
      end
   endtask : bus
   task automatic wait_st(input logic [4:0] s, input int lim);
      int n;
      for (n = 0; n < lim && power_state !== s; n++) @(posedge clk);
      chk("power_state", 32'(s), 32'(power_state));
      if (n == lim) complete_run();
   endtask : wait_st
   // Denied when protected and either no key or a lock is active
   function automatic logic deny_exp(input logic k, input logic l);
      return !k || l;
   endfunction : deny_exp
   task automatic acc_both();
      for (int w = 0; w < 2; w++)
      begin
         bus(1, OFS_ACCESS, 32'(w));
         chk("access_denied", 32'(deny_exp(kin, lk)), 32'(ev));
      end
   endtask : acc_both
   task automatic do_reset();
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      chk("state_in_reset", 32'h01, 32'(power_state));
      bus(1, OFS_IDLE_TIME, 32'h0000_0005);
      chk("early_refused", 1, 32'(ev));
      for (int n = 0; n < 300 && busy_n !== 1'b1; n++) @(posedge clk);
      wait_st(5'h02, 4);
      bus(0, OFS_IDLE_TIME, 0);
      chk("idle_time", IDLE_TIME_RST, rv);
   endtask : do_reset
   task automatic pulse();
      host_access <= 1'b1;
      @(posedge clk);
      host_access <= 1'b0;
   endtask : pulse
   initial
   begin
      do_reset();
      for (int i = 0; i < 4; i++)
      begin
         bus(0, OFS_SERIAL0 + 12'(4 * i), 0);
         chk("serial", sw[i], rv);
      end
      bus(1, OFS_SERIAL0, ~SERIAL_W0);
      bus(0, OFS_SERIAL0, 0);
      chk("serial_ro", SERIAL_W0, rv);
      $display("Test serial done");
      p = 2'($random(seed));
      key = {$random(seed), $random(seed)};
      bus(1, OFS_PART_SEL, 32'(p));
      bus(1, OFS_KEY_LO, key[31:0]);
      bus(1, OFS_KEY_HI, key[63:32]);
      bus(1, OFS_ATTR, 32'h0000_0007);
      kin = 0;
      lk = 0;
      acc_both();
      bus(1, OFS_KEY_LO, key[31:0] ^ 32'h0000_0001);
      bus(1, OFS_KEY_CMD, 32'h0000_0001);
      acc_both();
      bus(1, OFS_KEY_LO, key[31:0]);
      bus(1, OFS_KEY_CMD, 32'h0000_0001);
      kin = 1;
      acc_both();
      lock_n <= 1'b0;
      lk = 1;
      acc_both();
      lock_n <= 1'b1;
      lk = 0;
      bus(1, OFS_KEY_CMD, 32'h0000_0002);
      kin = 0;
      acc_both();
      bus(1, OFS_KEY_CMD, 32'h0000_0001);
      kin = 1;
      bus(1, OFS_SW_LOCK, 32'h0000_0001);
      lk = 1;
      acc_both();
      bus(1, OFS_SW_LOCK, 32'h0000_0000);
      bus(0, OFS_SW_LOCK, 0);
      chk("session_lock", 1, 32'(rv[0]));
      $display("Test protection done");
      bus(1, OFS_PART_SEL, 32'(p + 2'd1));
      bus(1, OFS_ATTR, 32'h0000_0008);
      bus(1, OFS_ACCESS, 32'h0000_0001);
      chk("once_first", 0, 32'(ev));
      bus(1, OFS_ACCESS, 32'h0000_0001);
      chk("once_second", 1, 32'(ev));
      bus(1, OFS_ACCESS, 32'h0000_0002);
      chk("once_erase", 1, 32'(ev));
      $display("Test write-once done");
      bus(1, OFS_POWER, 32'h0000_0001);
      wait_st(5'h04, 4);
      bus(1, OFS_IDLE_TIME, 32'h0000_0020);
      bus(1, OFS_POWER, 32'h0000_0004);
      wait_st(5'h10, 8);
      bus(0, OFS_IDLE_TIME, 0);
      chk("kept_value", 32'h0000_0020, rv);
      wait_st(5'h02, 4);
      bus(1, OFS_PART_SEL, 32'(p));
      kin = 0;
      acc_both();
      bus(1, OFS_POWER, 32'h0000_0002);
      repeat (6)
      begin
         repeat (15) @(posedge clk);
         pulse();
      end
      chk("timer_restart", 32'h02, 32'(power_state));
      wait_st(5'h08, 40);
      pulse();
      wait_st(5'h02, 2);
      bus(1, OFS_DEEP_TIME, 32'h0000_0020);
      bus(1, OFS_POWER, 32'h0000_001A);
      wait_st(5'h08, 40);
      wait_st(5'h10, 40);
      pulse();
      wait_st(5'h02, 4);
      bus(1, OFS_POWER, 32'h0000_0008);
      wait_st(5'h10, 40);
      $display("Test power done");
      do_reset();
      bus(0, OFS_SW_LOCK, 0);
      chk("lock_cleared", 0, 32'(rv[0]));
      $display("Test second reset done");
      complete_run();
   end
endmodule : test_partition_protect_power_modes
`default_nettype wire
